/* hdl/raes_top.v */
// Error detection and local status register of a PCI to VMEbus cable adapter
//
// Function
// - Any remote cycle ended by a bus error sets status bit 6 until command reset.
// - PCI side: target abort or no response in six cycles is a bus error.
// - VMEbus side: BERR or no answer within 48 to 54 us is a bus error.
// - PCI-started VME cycle over 30 us ends locally, sets timeout; VME cycle continues.
// - A late VME error is reported as bus error on the next PCI remote access.
// - Any remote access over its time limit sets status bit 2 until command reset.
// - VME-to-PCI accesses time out at 40 us; DMA never runs past 16 ms.
// - Local timeout is 28 us slave time plus 2 us access overhead.
// - Status bit 0 follows power loss or cable detach and clears by itself.
// - With the link down every remote access fails with an error status.
// - On contention the PCI requester is retried and the VME transfer finishes.
// - Cable data are checked on arrival; a mismatch sets status bit 7.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`include "raes_consts.vh"
module raes_top #(
  parameter        DATA_W  = 8,
  parameter [18:0] DMA_CYC = `RAES_CYC_DMA
) (
  input  wire              clk_sys_i,
  input  wire              reset_i,
  // Avalon-MM slave
  input  wire [3:0]        avs_address_i,
  input  wire              avs_read_i,
  input  wire              avs_write_i,
  input  wire [31:0]       avs_writedata_i,
  input  wire [3:0]        avs_byteenable_i,
  output reg  [31:0]       avs_readdata_o,
  output wire              avs_waitrequest_o,
  output wire              irq_o,
  // Link state pins
  input  wire              rmt_power_ok_i,
  input  wire              cable_present_i,
  // Cable receive data check
  input  wire              cable_valid_i,
  input  wire [DATA_W-1:0] cable_data_i,
  input  wire              cable_parity_i,
  // PCI master to remote VMEbus
  input  wire              pci_rmt_start_i,
  input  wire              vme_ack_i,
  input  wire              vme_berr_i,
  output reg               pci_rmt_ok_o,
  output reg               pci_rmt_err_o,
  output reg               pci_retry_o,
  output reg               vme_cyc_active_o,
  // VMEbus master to remote PCI
  input  wire              vme_rmt_start_i,
  input  wire              pci_devsel_i,
  input  wire              pci_tgt_abort_i,
  input  wire              pci_xfer_done_i,
  output reg               pci_bus_req_o,
  output reg               vme_rmt_ok_o,
  output reg               vme_rmt_err_o,
  // DMA watchdog
  input  wire              dma_active_i,
  output reg               dma_abort_o
);

  // ==========================================================================
  // PCI-to-VME cycle states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  // LATE: the local cycle has ended on timeout, the VME cycle still owns the remote bus
  localparam [2:0] ST_LATE = 3'b100;

  localparam [9:0]  LOCAL_CYC  = `RAES_CYC_LOCAL;
  localparam [10:0] VBUS_CYC   = `RAES_CYC_VBUS;
  localparam [9:0]  V2P_CYC    = `RAES_CYC_V2P;
  localparam [2:0]  NORESP_CYC = `RAES_PCI_NORESP_CYC;

  reg  [2:0] state;
  reg  [2:0] next_state;
  reg        pend_berr;
  reg        v2p_busy;
  reg        devsel_seen;
  reg  [7:0] status;
  reg  [7:0] irq_stat;
  reg  [7:0] irq_mask;
  reg        link_down_q;
  reg        bus_done;
  reg        pwr_meta;
  reg        pwr_sync;
  reg        cab_meta;
  reg        cab_sync;

  wire       link_down;
  wire       t_local;
  wire       t_vbus;
  wire       t_v2p;
  wire       t_noresp;
  wire       t_dma;

  // ==========================================================================
  // Link state synchroniser: both pins come from outside the clock domain
  // Resets to link down, so nothing remote is tried before both pins are seen high
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_meta <= 1'b0;
      pwr_sync <= 1'b0;
      cab_meta <= 1'b0;
      cab_sync <= 1'b0;
    end else begin
      pwr_meta <= rmt_power_ok_i;
      pwr_sync <= pwr_meta;
      cab_meta <= cable_present_i;
      cab_sync <= cab_meta;
    end
  end

  assign link_down = ~pwr_sync | ~cab_sync;

  // ==========================================================================
  // Watchdogs
  raes_timer #(.W(10), .LIMIT(LOCAL_CYC)) u_t_local (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .run_i     (state == ST_WAIT),
    .expired_o (t_local)
  );

  // Fires at the low edge of the 48 to 54 us window
  raes_timer #(.W(11), .LIMIT(VBUS_CYC)) u_t_vbus (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .run_i     (state != ST_IDLE),
    .expired_o (t_vbus)
  );

  raes_timer #(.W(10), .LIMIT(V2P_CYC)) u_t_v2p (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .run_i     (v2p_busy),
    .expired_o (t_v2p)
  );

  // No PCI clock here: the six bus cycles are counted in system clocks
  raes_timer #(.W(3), .LIMIT(NORESP_CYC)) u_t_noresp (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .run_i     (v2p_busy & ~devsel_seen & ~pci_devsel_i),
    .expired_o (t_noresp)
  );

  // One pulse per DMA run; the timeout bit it sets stays until command reset
  raes_timer #(.W(19), .LIMIT(DMA_CYC)) u_t_dma (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .run_i     (dma_active_i),
    .expired_o (t_dma)
  );

  // ==========================================================================
  // Contention: a VME-originated access owns the adapter, PCI gets a retry
  wire v2p_take  = vme_rmt_start_i & ~v2p_busy;
  // A PCI start is retried while any remote cycle is open; the requester must ask again
  wire p2v_retry = pci_rmt_start_i
                   & (v2p_busy | vme_rmt_start_i | (state != ST_IDLE));
  wire p2v_take  = pci_rmt_start_i & ~p2v_retry;

  // ==========================================================================
  // PCI-to-VME cycle sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (p2v_take && !link_down) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (link_down || vme_ack_i || vme_berr_i || t_vbus) begin
          next_state = ST_IDLE;
        end else if (t_local) begin
          next_state = ST_LATE;
        end
      end
      ST_LATE: begin
        if (link_down || vme_ack_i || vme_berr_i || t_vbus) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  wire p2v_fail_down = p2v_take & link_down;
  wire p2v_late_rpt  = p2v_take & ~link_down & pend_berr;
  wire p2v_berr      = (state == ST_WAIT) & ~link_down & ~vme_ack_i & (vme_berr_i | t_vbus);
  wire p2v_tmo       = (state == ST_WAIT) & ~link_down & ~vme_ack_i & ~vme_berr_i
                       & ~t_vbus & t_local;
  wire p2v_drop      = (state == ST_WAIT) & link_down;
  wire late_berr     = (state == ST_LATE) & ~link_down & ~vme_ack_i & (vme_berr_i | t_vbus);

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state            <= ST_IDLE;
      pend_berr        <= 1'b0;
      pci_rmt_ok_o     <= 1'b0;
      pci_rmt_err_o    <= 1'b0;
      pci_retry_o      <= 1'b0;
      vme_cyc_active_o <= 1'b0;
    end else begin
      state            <= next_state;
      vme_cyc_active_o <= (next_state != ST_IDLE);
      pci_retry_o      <= p2v_retry;
      pci_rmt_ok_o     <= (state == ST_WAIT) & ~link_down & vme_ack_i;
      pci_rmt_err_o    <= p2v_fail_down | p2v_late_rpt | p2v_berr | p2v_tmo | p2v_drop;
      // Held for the next PCI access; a lost link drops it since the remote side is gone
      if (late_berr) begin
        pend_berr <= 1'b1;
      end else if (p2v_late_rpt || link_down) begin
        pend_berr <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // VME-to-PCI access
  wire v2p_fail_down = v2p_take & link_down;
  wire v2p_berr      = v2p_busy & ~pci_xfer_done_i & (pci_tgt_abort_i | t_noresp);
  wire v2p_tmo       = v2p_busy & ~pci_xfer_done_i & ~pci_tgt_abort_i & ~t_noresp & t_v2p;
  wire v2p_ok        = v2p_busy & pci_xfer_done_i;

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      v2p_busy      <= 1'b0;
      devsel_seen   <= 1'b0;
      pci_bus_req_o <= 1'b0;
      vme_rmt_ok_o  <= 1'b0;
      vme_rmt_err_o <= 1'b0;
      dma_abort_o   <= 1'b0;
    end else begin
      if (v2p_take && !link_down) begin
        v2p_busy    <= 1'b1;
        devsel_seen <= 1'b0;
      end else if (v2p_ok || v2p_berr || v2p_tmo) begin
        v2p_busy    <= 1'b0;
      end else if (pci_devsel_i) begin
        devsel_seen <= 1'b1;
      end
      // The adapter wins the PCI bus for the VME-originated transfer
      pci_bus_req_o <= (v2p_take & ~link_down)
                       | (v2p_busy & ~(v2p_ok | v2p_berr | v2p_tmo));
      vme_rmt_ok_o  <= v2p_ok;
      vme_rmt_err_o <= v2p_fail_down | v2p_berr | v2p_tmo;
      dma_abort_o   <= t_dma;
    end
  end

  // ==========================================================================
  // Error events
  wire ev_data  = cable_valid_i & ((^cable_data_i) != cable_parity_i);
  wire ev_rbus  = p2v_late_rpt | p2v_berr | v2p_berr;
  wire ev_tmo   = p2v_fail_down | v2p_fail_down | p2v_tmo | p2v_drop
                  | v2p_tmo | t_dma;
  wire ev_down  = link_down & ~link_down_q;

  // ==========================================================================
  // Avalon-MM slave: one wait state, effects at the edge with waitrequest low
  wire       bus_req  = avs_read_i | avs_write_i;
  wire       wr_en    = avs_write_i & bus_done & avs_byteenable_i[0];
  wire       wr_cmd   = wr_en & (avs_address_i[3:2] == `RAES_OFS_COMMAND >> 2);
  wire       wr_istat = wr_en & (avs_address_i[3:2] == `RAES_OFS_IRQ_STAT >> 2);
  wire       wr_imask = wr_en & (avs_address_i[3:2] == `RAES_OFS_IRQ_MASK >> 2);
  wire       cmd_clr  = wr_cmd & avs_writedata_i[`RAES_BIT_CMD_CLEAR];
  wire [7:0] ev_vec   = {ev_data, ev_rbus, 3'b000, ev_tmo, 1'b0, ev_down};
  wire [7:0] sticky   = {ev_data, ev_rbus, 3'b000, ev_tmo, 2'b00};
  reg  [7:0] next_status;
  reg  [31:0] next_rdata;

  // Exactly one wait state: the answer never comes in the cycle the request appears
  assign avs_waitrequest_o = bus_req & ~bus_done;

  always @* begin
    next_status = status;
    if (cmd_clr) begin
      next_status = status & ~`RAES_STICKY_MASK;
    end
    next_status = next_status | sticky;
    next_status[`RAES_BIT_LINK_DOWN] = link_down;
  end

  // The write-only command word reads as zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (avs_address_i[3:2])
      2'h0:    next_rdata = {24'h00_0000, status};
      2'h2:    next_rdata = {24'h00_0000, irq_stat};
      2'h3:    next_rdata = {24'h00_0000, irq_mask};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data are captured in the wait cycle and stand at the answer edge
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bus_done       <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      bus_done <= bus_req & ~bus_done;
      if (avs_read_i && !bus_done) begin
        avs_readdata_o <= next_rdata;
      end
    end
  end

  // ==========================================================================
  // Status register and link edge detector
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      status      <= `RAES_RST_STATUS;
      link_down_q <= 1'b0;
    end else begin
      status      <= next_status;
      link_down_q <= link_down;
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_stat <= `RAES_RST_IRQ_STAT;
      irq_mask <= `RAES_RST_IRQ_MASK;
    end else begin
      // New events win over a write-one-to-clear in the same cycle
      if (wr_istat) begin
        irq_stat <= (irq_stat & ~avs_writedata_i[7:0]) | ev_vec;
      end else begin
        irq_stat <= irq_stat | ev_vec;
      end
      if (wr_imask) begin
        irq_mask <= avs_writedata_i[7:0] & `RAES_IRQ_MASK_USED;
      end
    end
  end

  // Level output; software clears the cause through the irq status word
  assign irq_o = |(irq_stat & irq_mask);

endmodule // raes_top

/* hdl/raes_consts.vh */
// Register map, field positions, reset values and timing counts of the remote error status block
`ifndef RAES_CONSTS_VH
`define RAES_CONSTS_VH

// ==========================================================================
// Register byte offsets
`define RAES_OFS_STATUS     4'h0
`define RAES_OFS_COMMAND    4'h4
`define RAES_OFS_IRQ_STAT   4'h8
`define RAES_OFS_IRQ_MASK   4'hc

// ==========================================================================
// Field positions in local_error_status, irq status and irq mask
`define RAES_BIT_DATA_ERR   7
`define RAES_BIT_RBUS_ERR   6
`define RAES_BIT_TIMEOUT    2
`define RAES_BIT_LINK_DOWN  0
`define RAES_BIT_CMD_CLEAR  0
`define RAES_STICKY_MASK    8'hc4
`define RAES_IRQ_MASK_USED  8'hc5

// ==========================================================================
// Reset values
`define RAES_RST_STATUS     8'h00
`define RAES_RST_IRQ_STAT   8'h00
`define RAES_RST_IRQ_MASK   8'h00

// ==========================================================================
// Times in their own units and cycle counts at the system clock
`define RAES_CLK_NS         40
`define RAES_NS_PER_US      1000
`define RAES_T_SLAVE_US     28
`define RAES_T_OVERHEAD_US  2
`define RAES_T_VBUS_US      48
`define RAES_T_V2P_US       40
`define RAES_T_DMA_MS       16
`define RAES_PCI_NORESP_CYC 6
`define RAES_CYC_LOCAL \
  (((`RAES_T_SLAVE_US + `RAES_T_OVERHEAD_US) * `RAES_NS_PER_US + `RAES_CLK_NS - 1) / `RAES_CLK_NS)
`define RAES_CYC_VBUS \
  ((`RAES_T_VBUS_US * `RAES_NS_PER_US + `RAES_CLK_NS - 1) / `RAES_CLK_NS)
`define RAES_CYC_V2P \
  ((`RAES_T_V2P_US * `RAES_NS_PER_US + `RAES_CLK_NS - 1) / `RAES_CLK_NS)
`define RAES_CYC_DMA \
  ((`RAES_T_DMA_MS * 1000 * `RAES_NS_PER_US) / `RAES_CLK_NS)

`endif

/* hdl/raes_timer.v */
// Watchdog counter that pulses once when a run level has lasted LIMIT cycles
`timescale 1ns/1ns
module raes_timer #(
  parameter         W     = 11,
  parameter [W-1:0] LIMIT = 11'd750
) (
  input  wire       clk_sys_i,
  input  wire       reset_i,
  input  wire       run_i,
  output reg        expired_o
);

  reg [W-1:0] count;

  // ==========================================================================
  // Counter saturates at the limit so the pulse fires only once per run
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      count     <= {W{1'b0}};
      expired_o <= 1'b0;
    end else if (!run_i) begin
      count     <= {W{1'b0}};
      expired_o <= 1'b0;
    end else begin
      if (count != LIMIT) begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
      expired_o <= (count == LIMIT - {{(W-1){1'b0}}, 1'b1});
    end
  end

endmodule // raes_timer

/* test/raes_far_model.sv */
// Behavioural model of the remote adapter card with its remote VMEbus slave and PCI target
`timescale 1ns/1ns
module raes_far_model #(
  parameter DELAY = 10
) (
  input  wire       clk_sys_i,
  input  wire       vme_cyc_i,
  input  wire       bus_req_i,
  input  wire [1:0] mode_i,
  output reg        vme_ack_o,
  output reg        vme_berr_o,
  output reg        pci_devsel_o,
  output reg        pci_tgt_abort_o,
  output reg        pci_xfer_done_o
);
  // Modes: 0 answers, 1 errors, 2 silent, 3 claims the PCI cycle but never ends it
  reg [15:0] cnt = 16'h0;
  initial begin
    {vme_ack_o, vme_berr_o, pci_devsel_o, pci_tgt_abort_o, pci_xfer_done_o} = 5'h0;
  end
  always @(posedge clk_sys_i) begin
    cnt             <= (vme_cyc_i || bus_req_i) ? cnt + 16'h1 : 16'h0;
    vme_ack_o       <= vme_cyc_i && cnt == DELAY && mode_i == 2'h0;
    vme_berr_o      <= vme_cyc_i && cnt == DELAY && mode_i == 2'h1;
    pci_devsel_o    <= bus_req_i && cnt != 16'h0 && mode_i != 2'h2;
    pci_tgt_abort_o <= bus_req_i && cnt == DELAY && mode_i == 2'h1;
    pci_xfer_done_o <= bus_req_i && cnt == DELAY && mode_i == 2'h0;
  end
endmodule // raes_far_model

/* test/raes_properties.sv */
// Port-level checks of the remote error status block
`timescale 1ns/1ns
module raes_properties #(
  parameter [18:0] DMA_CYC = 19'd50
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire avs_waitrequest_o,
  input wire rmt_power_ok_i,
  input wire pci_rmt_start_i,
  input wire vme_berr_i,
  input wire pci_rmt_err_o,
  input wire pci_retry_o,
  input wire vme_cyc_active_o,
  input wire vme_rmt_start_i,
  input wire pci_devsel_i,
  input wire pci_tgt_abort_i,
  input wire pci_bus_req_o,
  input wire vme_rmt_err_o,
  input wire dma_active_i,
  input wire dma_abort_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // ==========================================================================
  // Cycle counters: long waits are counted here, not unrolled in properties
  reg [15:0] vcnt;
  reg [3:0]  pcnt;
  reg [18:0] dcnt;
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      vcnt <= 16'h0;
      pcnt <= 4'h0;
      dcnt <= 19'h0;
    end else begin
      vcnt <= vme_cyc_active_o ? vcnt + 16'h1 : 16'h0;
      pcnt <= (pci_bus_req_o && !pci_devsel_i) ? pcnt + 4'h1 : 4'h0;
      dcnt <= dma_active_i ? dcnt + 19'h1 : 19'h0;
    end
  end
  // ==========================================================================
  // Properties
  sequence s_link_lost;
    (!rmt_power_ok_i)[*4];
  endsequence
  sequence s_free_start;
    pci_rmt_start_i && !vme_cyc_active_o && !pci_bus_req_o;
  endsequence
  chk_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("waitrequest held over one cycle");
  chk_busy_retry: assert property (pci_rmt_start_i && vme_cyc_active_o
    |=> pci_retry_o && !pci_rmt_err_o) else $error("no retry while remote cycle busy");
  chk_contend_retry: assert property (s_free_start ##0 vme_rmt_start_i
    |=> pci_retry_o) else $error("no retry on contention");
  chk_berr_ends: assert property (vme_cyc_active_o && vme_berr_i
    |=> !vme_cyc_active_o) else $error("remote cycle still active after bus error");
  chk_local_tmo: assert property (vme_cyc_active_o && vcnt == 16'd749
    |-> ##[0:2] pci_rmt_err_o) else $error("local timeout missing");
  chk_tmo_early: assert property (vme_cyc_active_o && vcnt > 16'd1 && vcnt < 16'd740
    |-> !pci_rmt_err_o) else $error("local timeout too early");
  chk_bus_tmo: assert property (vme_cyc_active_o |-> vcnt < 16'd1203)
    else $error("remote cycle outlived bus timeout");
  chk_abort_err: assert property (pci_bus_req_o && pci_tgt_abort_i
    |=> vme_rmt_err_o && !pci_bus_req_o) else $error("target abort not reported");
  chk_noresp_err: assert property (pci_bus_req_o |-> pcnt < 4'd9)
    else $error("unclaimed PCI cycle not ended");
  chk_dma_limit: assert property (dma_active_i && dcnt == DMA_CYC - 19'h1
    |-> ##[0:2] dma_abort_o) else $error("DMA limit not enforced");
  chk_link_fail: assert property (s_link_lost ##0 s_free_start ##0 !vme_rmt_start_i
    |=> pci_rmt_err_o) else $error("access with link down not failed");
endmodule // raes_properties

bind raes_top raes_properties #(.DMA_CYC(DMA_CYC)) i_raes_properties (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .rmt_power_ok_i(rmt_power_ok_i), .pci_rmt_start_i(pci_rmt_start_i),
  .vme_berr_i(vme_berr_i), .pci_rmt_err_o(pci_rmt_err_o), .pci_retry_o(pci_retry_o),
  .vme_cyc_active_o(vme_cyc_active_o), .vme_rmt_start_i(vme_rmt_start_i),
  .pci_devsel_i(pci_devsel_i), .pci_tgt_abort_i(pci_tgt_abort_i),
  .pci_bus_req_o(pci_bus_req_o), .vme_rmt_err_o(vme_rmt_err_o),
  .dma_active_i(dma_active_i), .dma_abort_o(dma_abort_o));

/* test/remote_access_error_status_test.sv */
// Self-checking bench of the remote error status block
`timescale 1ns/1ns
module remote_access_error_status_test;
  localparam [18:0] DMA_CYC = 19'd50;
  reg         clk_sys_i, reset_i, avs_read_i, avs_write_i, rmt_power_ok_i, cable_present_i;
  reg  [3:0]  avs_address_i, avs_byteenable_i;
  reg  [31:0] avs_writedata_i;
  reg  [7:0]  cable_data_i;
  reg         cable_valid_i, cable_parity_i, pci_rmt_start_i, vme_rmt_start_i, dma_active_i;
  reg  [1:0]  mode;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o, irq_o, vme_ack_i, vme_berr_i, pci_devsel_i, pci_tgt_abort_i;
  wire        pci_xfer_done_i, pci_rmt_ok_o, pci_rmt_err_o, pci_retry_o, vme_cyc_active_o;
  wire        pci_bus_req_o, vme_rmt_ok_o, vme_rmt_err_o, dma_abort_o;
  integer     miscompares = 0;
  integer     check_count = 0;

  raes_top #(.DMA_CYC(DMA_CYC)) i_raes_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
    .rmt_power_ok_i(rmt_power_ok_i), .cable_present_i(cable_present_i),
    .cable_valid_i(cable_valid_i), .cable_data_i(cable_data_i),
    .cable_parity_i(cable_parity_i), .pci_rmt_start_i(pci_rmt_start_i),
    .vme_ack_i(vme_ack_i), .vme_berr_i(vme_berr_i), .pci_rmt_ok_o(pci_rmt_ok_o),
    .pci_rmt_err_o(pci_rmt_err_o), .pci_retry_o(pci_retry_o),
    .vme_cyc_active_o(vme_cyc_active_o), .vme_rmt_start_i(vme_rmt_start_i),
    .pci_devsel_i(pci_devsel_i), .pci_tgt_abort_i(pci_tgt_abort_i),
    .pci_xfer_done_i(pci_xfer_done_i), .pci_bus_req_o(pci_bus_req_o),
    .vme_rmt_ok_o(vme_rmt_ok_o), .vme_rmt_err_o(vme_rmt_err_o),
    .dma_active_i(dma_active_i), .dma_abort_o(dma_abort_o));

  raes_far_model i_raes_far_model (.clk_sys_i(clk_sys_i), .vme_cyc_i(vme_cyc_active_o),
    .bus_req_i(pci_bus_req_o), .mode_i(mode), .vme_ack_o(vme_ack_i), .vme_berr_o(vme_berr_i),
    .pci_devsel_o(pci_devsel_i), .pci_tgt_abort_o(pci_tgt_abort_i),
    .pci_xfer_done_o(pci_xfer_done_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // ==========================================================================
  // Shared tasks
  task chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs are read at the edge itself, before that edge's updates land
  task bus(input w, input [3:0] a, input [7:0] d, input [3:0] be, input [7:0] e);
    integer n;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do begin @(posedge clk_sys_i); n = n + 1; end while (avs_waitrequest_o !== 1'b0 && n < 50);
    chk(avs_waitrequest_o, 1'b0);
    if (!w) chk(avs_readdata_o, {24'h0, e});
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // Let the answer edge's register updates land before the caller looks
    @(posedge clk_sys_i);
  endtask
  task rd(input [3:0] a, input [7:0] e); bus(1'b0, a, 8'h0, 4'hf, e); endtask
  task wr(input [3:0] a, input [7:0] d); bus(1'b1, a, d, 4'hf, 8'h0); endtask
  // sel bit0 starts from the PCI side, bit1 from the VMEbus side
  task xfer(input [1:0] sel, input [1:0] m, input [2:0] exp, input idle);
    reg [2:0] got;
    integer n;
    @(posedge clk_sys_i);
    mode <= m;
    pci_rmt_start_i <= sel[0];
    vme_rmt_start_i <= sel[1];
    @(posedge clk_sys_i);
    pci_rmt_start_i <= 1'b0;
    vme_rmt_start_i <= 1'b0;
    got = 3'h0;
    for (n = 0; got === 3'h0 && n < 1500; n = n + 1) begin
      @(posedge clk_sys_i);
      got = sel[0] ? {pci_retry_o, pci_rmt_err_o, pci_rmt_ok_o}
                   : {1'b0, vme_rmt_err_o, vme_rmt_ok_o};
    end
    chk({29'h0, got}, {29'h0, exp});
    for (n = 0; idle && (vme_cyc_active_o || pci_bus_req_o) && n < 1500; n = n + 1)
      @(posedge clk_sys_i);
  endtask
  // ==========================================================================
  // Scenarios
  task t_regs_irq;
    rd(4'h0, 8'h01);
    rd(4'h4, 8'h00);
    rd(4'hc, 8'h00);
    rmt_power_ok_i <= 1'b1;
    cable_present_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rd(4'h0, 8'h00);
    rd(4'h8, 8'h01);
    chk(irq_o, 1'b0);
    wr(4'hc, 8'h01);
    chk(irq_o, 1'b1);
    wr(4'h8, 8'h01);
    chk(irq_o, 1'b0);
  endtask
  task t_pci;
    xfer(2'h1, 2'h0, 3'h1, 1'b1);
    xfer(2'h1, 2'h1, 3'h2, 1'b1);
    wr(4'h0, 8'hff);
    bus(1'b1, 4'h4, 8'h01, 4'h0, 8'h0);
    rd(4'h0, 8'h40);
    wr(4'h4, 8'h01);
    rd(4'h0, 8'h00);
  endtask
  task t_timeout;
    xfer(2'h1, 2'h2, 3'h2, 1'b0);
    chk(vme_cyc_active_o, 1'b1);
    rd(4'h0, 8'h04);
    xfer(2'h1, 2'h0, 3'h4, 1'b1);
    xfer(2'h1, 2'h0, 3'h2, 1'b1);
    rd(4'h0, 8'h44);
    wr(4'h4, 8'h01);
  endtask
  task t_v2p;
    xfer(2'h2, 2'h0, 3'h1, 1'b1);
    xfer(2'h2, 2'h1, 3'h2, 1'b1);
    xfer(2'h2, 2'h2, 3'h2, 1'b1);
    rd(4'h0, 8'h40);
    wr(4'h4, 8'h01);
    xfer(2'h2, 2'h3, 3'h2, 1'b1);
    rd(4'h0, 8'h04);
    xfer(2'h3, 2'h0, 3'h4, 1'b1);
    xfer(2'h1, 2'h0, 3'h1, 1'b1);
    wr(4'h4, 8'h01);
  endtask
  task cable(input [7:0] d, input p, input [7:0] e);
    @(posedge clk_sys_i);
    cable_valid_i <= 1'b1;
    cable_data_i <= d;
    cable_parity_i <= p;
    @(posedge clk_sys_i);
    cable_valid_i <= 1'b0;
    rd(4'h0, e);
  endtask
  task t_dma_link;
    cable(8'h03, 1'b0, 8'h00);
    cable(8'h07, 1'b0, 8'h80);
    wr(4'h4, 8'h01);
    wr(4'h8, 8'hc5);
    wr(4'hc, 8'h04);
    chk(irq_o, 1'b0);
    dma_active_i <= 1'b1;
    repeat (DMA_CYC + 3) @(posedge clk_sys_i);
    dma_active_i <= 1'b0;
    chk(irq_o, 1'b1);
    rd(4'h0, 8'h04);
    rmt_power_ok_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    xfer(2'h1, 2'h0, 3'h2, 1'b1);
    rd(4'h0, 8'h05);
    rmt_power_ok_i <= 1'b1;
    cable_present_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    xfer(2'h2, 2'h0, 3'h2, 1'b1);
    rd(4'h0, 8'h05);
    wr(4'h4, 8'h01);
    rd(4'h0, 8'h01);
    cable_present_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rd(4'h0, 8'h00);
  endtask
  task end_of_test;
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    {reset_i, avs_read_i, avs_write_i, rmt_power_ok_i, cable_present_i} = 5'h10;
    {avs_address_i, avs_byteenable_i, avs_writedata_i, cable_data_i, mode} = 50'h0;
    {cable_valid_i, cable_parity_i, pci_rmt_start_i, vme_rmt_start_i, dma_active_i} = 5'h0;
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_regs_irq;
    t_pci;
    t_timeout;
    t_v2p;
    t_dma_link;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares = miscompares + 1;
    end_of_test;
  end
endmodule // remote_access_error_status_test
